// >>> hw/alert_defs.vh
`ifndef ALERT_DEFS_VH
`define ALERT_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CFG1        8'h01
`define OFS_CFG4        8'h04
`define OFS_FQ          8'h06
`define OFS_MASK1       8'h08
`define OFS_MASK2       8'h09
`define OFS_MASK3       8'h0A
`define OFS_STAT1       8'h4F
`define OFS_STAT2       8'h50
`define OFS_STAT3       8'h51
// ----------------------------------------
// field positions
// ----------------------------------------
`define B_LOC_HI        7
`define B_LOC_LO        6
`define B_RH            5
`define B_RL            4
`define B_RD            3
`define B_LOC_CRIT      7
`define B_RT            6
`define B_ONT           4
`define B_PIN_ACT       3
`define B_PIN_STATE     2
`define B_STALL         7
`define B_ALARM         6
`define B_ALOW          0
`define B_COMP          3
`define B_REFSEL        7
// ----------------------------------------
// reset values and valid bit masks
// ----------------------------------------
`define RST_MASK        8'h00
`define RST_CFG         8'h00
`define VALID1          8'hF8
`define VALID2          8'hDC
`define VALID3          8'hC0
`define VALIDM2         8'h1C
`define FQ_W            3
`endif

// >>> hw/fault_queue.v
`timescale 1ns/1ns
`include "alert_defs.vh"
// per-channel consecutive out-of-limit counter
module fault_queue #(
    parameter W = `FQ_W
) (
    input  wire         clk_sys_i,
    input  wire         rst_i,
    input  wire         ce_i,
    input  wire         clr_i,
    input  wire         sample_i,
    input  wire         oor_i,
    input  wire [W-1:0] len_i,
    output reg          full_o
);
    reg [W-1:0] cnt;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt    <= {W{1'b0}};
            full_o <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                // a reading that lands with the clear still counts
                if (sample_i && oor_i) begin
                    cnt    <= {{(W-1){1'b0}}, 1'b1};
                    full_o <= (len_i <= {{(W-1){1'b0}}, 1'b1});
                end else begin
                    cnt    <= {W{1'b0}};
                    full_o <= 1'b0;
                end
            end else if (sample_i) begin
                if (!oor_i) begin
                    cnt <= {W{1'b0}};
                end else if (cnt < len_i) begin
                    cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
                    if (cnt + {{(W-1){1'b0}}, 1'b1} >= len_i)
                        full_o <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> hw/limit_compare.v
`timescale 1ns/1ns
`include "alert_defs.vh"
// high/low limit comparator for one reading
module limit_compare #(
    parameter W = 8
) (
    input  wire [W-1:0] value_i,
    input  wire [W-1:0] high_i,
    input  wire [W-1:0] low_i,
    output wire         high_o,
    output wire         low_o
);
    assign high_o = (value_i >= high_i);
    assign low_o  = (value_i <  low_i);
endmodule

// >>> hw/alert_status_mask_logic.v
`timescale 1ns/1ns
`include "alert_defs.vh"
// Overview of operation
// [R01] status one: local/remote high, low, diode
// [R02] status two: crit, on-time, active, pin state
// [R03] active flag: crit exceeded and pin driven
// [R04] pin state read-clear only when inactive
// [R05] status three: stall, alarm, alert-low bit
// [R06] unmasked out-of-limit asserts alert
// [R07] config bit 3 selects latched or comparator
// [R08] latched: hold until in-limit and serviced; queued temperature sources drop on ARA or status one read
// [R09] one clear keeps other active sources
// [R10] comparator: follows live out-of-limit state
// [R11] masks gate alert, status still sets
// [R12] mask one mirrors status one positions
// [R13] mask two: on-time, active, pin state
// [R14] mask three: stall and alarm speed
// [R15] host masks, services, polls, unmasks
// [R16] fan fault pin or reference input
// [R17] fault queue: temperatures, latched mode only
// [R18] one queue counter per temperature channel
// [R19] queue length decoded from bits 3:0
// [R20] queue reset by ARA, status one read, reset
// [R21] sticky status until in-limit and serviced
// [R22] high uses >=, low uses <
// [R23] alert is active-low open-drain
module alert_status_mask_logic #(
    parameter TW = 8
) (
    input  wire          clk_sys_i,
    input  wire          rst_i,
    input  wire          ce_i,
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    input  wire [7:0]    reg_addr_i,
    input  wire [7:0]    reg_wdata_i,
    input  wire          ara_done_i,
    input  wire          local_sample_i,
    input  wire          remote_sample_i,
    input  wire [TW-1:0] local_temp_i,
    input  wire [TW-1:0] remote_temp_i,
    input  wire [TW-1:0] local_high_lim_i,
    input  wire [TW-1:0] local_low_lim_i,
    input  wire [TW-1:0] remote_high_lim_i,
    input  wire [TW-1:0] remote_low_lim_i,
    input  wire          diode_fault_i,
    input  wire          local_crit_i,
    input  wire          remote_crit_i,
    input  wire          ontime_exceed_i,
    input  wire          overtemp_pin_drive_i,
    input  wire          overtemp_pin_i,
    input  wire          fan_stall_i,
    input  wire          fan_alarm_i,
    output reg  [7:0]    reg_rdata_o,
    output reg           alert_o,
    output reg           alert_oe_o,
    output reg           cooler_stall_output_o,
    output reg           cooler_stall_oe_o,
    output reg           ref_select_o
);
    // ----------------------------------------
    // configuration and masks
    // ----------------------------------------
    reg [7:0] cfg1;
    reg [7:0] cfg4;
    reg [7:0] fq_cfg;
    reg [7:0] limit_mask_one;
    reg [7:0] pin_event_mask;
    reg [7:0] cooler_event_mask;
    reg [7:0] limit_status_one;
    reg [7:0] pin_event_status;
    reg [7:0] cooler_alert_status;
    wire comp_mode = cfg1[`B_COMP]; // R07
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg1              <= `RST_CFG;
            cfg4              <= `RST_CFG;
            fq_cfg            <= `RST_CFG;
            limit_mask_one    <= `RST_MASK;
            pin_event_mask    <= `RST_MASK;
            cooler_event_mask <= `RST_MASK;
        end else if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                `OFS_CFG1:  cfg1 <= reg_wdata_i; // R07
                `OFS_CFG4:  cfg4 <= reg_wdata_i;
                `OFS_FQ:    fq_cfg <= reg_wdata_i;
                `OFS_MASK1: limit_mask_one <= reg_wdata_i & `VALID1; // R12
                `OFS_MASK2: pin_event_mask <= reg_wdata_i & `VALIDM2; // R13
                `OFS_MASK3: cooler_event_mask <= reg_wdata_i & `VALID3; // R14
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // limit comparisons
    // ----------------------------------------
    wire loc_hi_now;
    wire loc_lo_now;
    wire rem_hi_now;
    wire rem_lo_now;
    limit_compare #(.W(TW)) u_local (
        .value_i (local_temp_i),
        .high_i  (local_high_lim_i),
        .low_i   (local_low_lim_i),
        .high_o  (loc_hi_now),
        .low_o   (loc_lo_now)
    ); // R22
    limit_compare #(.W(TW)) u_remote (
        .value_i (remote_temp_i),
        .high_i  (remote_high_lim_i),
        .low_i   (remote_low_lim_i),
        .high_o  (rem_hi_now),
        .low_o   (rem_lo_now)
    ); // R22
    // ----------------------------------------
    // fault queues
    // ----------------------------------------
    function [2:0] fq_len;
        input [3:0] code;
        begin
            if (code[3])
                fq_len = 3'd4;
            else if (code[2])
                fq_len = 3'd3;
            else if (code[1])
                fq_len = 3'd2;
            else
                fq_len = 3'd1;
        end
    endfunction
    wire [2:0] qlen = fq_len(fq_cfg[3:0]); // R19
    wire rd1 = ce_i && reg_rd_i && (reg_addr_i == `OFS_STAT1);
    wire rd2 = ce_i && reg_rd_i && (reg_addr_i == `OFS_STAT2);
    wire rd3 = ce_i && reg_rd_i && (reg_addr_i == `OFS_STAT3);
    wire q_clr = rd1 || (ce_i && ara_done_i); // R20
    wire lq_full;
    wire rq_full;
    fault_queue #(.W(`FQ_W)) u_lq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (q_clr),
        .sample_i  (local_sample_i),
        .oor_i     (loc_hi_now | loc_lo_now),
        .len_i     (qlen),
        .full_o    (lq_full)
    ); // R18
    fault_queue #(.W(`FQ_W)) u_rq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (q_clr),
        .sample_i  (remote_sample_i),
        .oor_i     (rem_hi_now | rem_lo_now | diode_fault_i),
        .len_i     (qlen),
        .full_o    (rq_full)
    ); // R18
    // ----------------------------------------
    // live conditions and sticky status
    // ----------------------------------------
    wire [7:0] live1 = {loc_hi_now, loc_lo_now, rem_hi_now, rem_lo_now, diode_fault_i, 3'b000}; // R01
    wire       pin_act_now = (local_crit_i | remote_crit_i) & overtemp_pin_drive_i; // R03
    wire [7:0] live2 = {local_crit_i, remote_crit_i, 1'b0, ontime_exceed_i,
                        pin_act_now, overtemp_pin_i, 2'b00}; // R02 R04
    wire [7:0] live3 = {fan_stall_i, fan_alarm_i, 6'b000000}; // R05
    wire       ara   = ce_i && ara_done_i;
    // bit stays while live; read/ARA clears only bits whose cause is gone
    function [7:0] sticky;
        input [7:0] cur;
        input [7:0] live;
        input       clr;
        begin
            sticky = clr ? live : (cur | live);
        end
    endfunction
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            limit_status_one    <= 8'h00;
            pin_event_status    <= 8'h00;
            cooler_alert_status <= 8'h00;
        end else if (ce_i) begin
            limit_status_one    <= sticky(limit_status_one, live1, rd1 | ara); // R21 R11
            pin_event_status    <= sticky(pin_event_status, live2, rd2 | ara); // R21 R04
            cooler_alert_status <= sticky(cooler_alert_status, live3, rd3 | ara); // R21
        end
    end
    // ----------------------------------------
    // alert generation
    // ----------------------------------------
    wire [7:0] temp_gate = comp_mode ? 8'hFF :
                           {lq_full, lq_full, rq_full, rq_full, rq_full, 3'b111}; // R17
    wire [7:0] pin_cmp_blk = comp_mode ? (8'h01 << `B_PIN_STATE) : 8'h00; // R04 R13
    wire src_sticky = |(limit_status_one & ~limit_mask_one & temp_gate & `VALID1)
                    | |(pin_event_status & ~pin_event_mask & `VALID2)
                    | |(cooler_alert_status & ~cooler_event_mask & `VALID3); // R06 R11
    wire src_live   = |(live1 & ~limit_mask_one & `VALID1)
                    | |(live2 & ~(pin_event_mask | pin_cmp_blk) & `VALID2 & ~pin_cmp_blk)
                    | |(live3 & ~cooler_event_mask & `VALID3); // R10 R06
    // latched: held by the sticky bits, dropped by an emptied queue
    wire next_assert = comp_mode ? src_live : src_sticky; // R08 R09 R10 R20
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            alert_o               <= 1'b0;
            alert_oe_o            <= 1'b0;
            cooler_stall_output_o <= 1'b0;
            cooler_stall_oe_o     <= 1'b0;
            ref_select_o          <= 1'b0;
            reg_rdata_o           <= 8'h00;
        end else if (ce_i) begin
            alert_o               <= 1'b0; // R23
            alert_oe_o            <= next_assert; // R23
            ref_select_o          <= cfg4[`B_REFSEL]; // R16
            cooler_stall_output_o <= 1'b0; // R16
            cooler_stall_oe_o     <= ~cfg4[`B_REFSEL] & fan_stall_i; // R16
            case (reg_addr_i)
                `OFS_CFG1:  reg_rdata_o <= cfg1;
                `OFS_CFG4:  reg_rdata_o <= cfg4;
                `OFS_FQ:    reg_rdata_o <= fq_cfg;
                `OFS_MASK1: reg_rdata_o <= limit_mask_one;
                `OFS_MASK2: reg_rdata_o <= pin_event_mask;
                `OFS_MASK3: reg_rdata_o <= cooler_event_mask;
                `OFS_STAT1: reg_rdata_o <= limit_status_one;
                `OFS_STAT2: reg_rdata_o <= pin_event_status;
                `OFS_STAT3: reg_rdata_o <= cooler_alert_status | {7'b0000000, alert_oe_o}; // R05
                default:    reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// >>> verification/alert_host_model.sv
`timescale 1ns/1ns
module alert_host_model (
    input  wire       clk_sys_i,
    input  wire       alert_oe_i,
    input  wire       ara_req_i,
    input  wire [3:0] delay_i,
    output wire       alert_line_o,
    output reg        ara_done_o = 1'b0
);
    reg [3:0] cnt = 4'h0;
    // pull-up wins unless the device sinks the line
    assign alert_line_o = alert_oe_i ? 1'b0 : 1'b1;
    // one ARA completion per low stretch of the line while requested, after a chosen wait below 15 (a wait of 15 repeats every cycle)
    always @(posedge clk_sys_i) begin
        ara_done_o <= ara_req_i && !alert_line_o && (cnt == delay_i);
        if (!ara_req_i || alert_line_o)
            cnt <= 4'h0;
        else if (cnt != 4'hF)
            cnt <= cnt + 4'h1;
    end
endmodule

// >>> verification/alert_status_mask_logic_properties.sv
`timescale 1ns/1ns
module alert_props (
    input wire       clk_sys_i,
    input wire       rst_i,
    input wire       ce_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       ara_done_i,
    input wire       fan_stall_i,
    input wire [7:0] reg_rdata_o,
    input wire       alert_o,
    input wire       alert_oe_o,
    input wire       cooler_stall_output_o,
    input wire       cooler_stall_oe_o,
    input wire       ref_select_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    reg  comp;
    wire svc = ce_i && (reg_wr_i || reg_rd_i || ara_done_i);
    always @(posedge clk_sys_i) begin
        if (rst_i)
            comp <= 1'b0;
        else if (ce_i && reg_wr_i && reg_addr_i == 8'h01)
            comp <= reg_wdata_i[3];
    end
    property p_od; alert_o == 1'b0 && cooler_stall_output_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("pin data not low");
    property p_rsv1; ce_i && reg_addr_i == 8'h4F |=> reg_rdata_o[2:0] == 3'h0; endproperty
    a_rsv1: assert property (p_rsv1) else $error("status one reserved set");
    property p_rsv2; ce_i && reg_addr_i == 8'h50 |=> (reg_rdata_o & 8'h23) == 8'h00; endproperty
    a_rsv2: assert property (p_rsv2) else $error("status two reserved set");
    property p_rsv3; ce_i && reg_addr_i == 8'h51 |=> reg_rdata_o[5:1] == 5'h00; endproperty
    a_rsv3: assert property (p_rsv3) else $error("status three reserved set");
    property p_msk1; ce_i && reg_addr_i == 8'h08 |=> reg_rdata_o[2:0] == 3'h0; endproperty
    a_msk1: assert property (p_msk1) else $error("mask one reserved set");
    property p_msk2; ce_i && reg_addr_i == 8'h09 |=> (reg_rdata_o & 8'hE3) == 8'h00; endproperty
    a_msk2: assert property (p_msk2) else $error("mask two reserved set");
    property p_msk3; ce_i && reg_addr_i == 8'h0A |=> reg_rdata_o[5:0] == 6'h00; endproperty
    a_msk3: assert property (p_msk3) else $error("mask three reserved set");
    property p_hold; !comp && $fell(alert_oe_o) |-> $past(svc, 1) || $past(svc, 2); endproperty
    a_hold: assert property (p_hold) else $error("latched alert released unserviced");
    property p_ref; ce_i && reg_wr_i && reg_addr_i == 8'h04 |-> ##2 ref_select_o == $past(reg_wdata_i[7], 2); endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    property p_stall; (!ref_select_o && fan_stall_i) [*3] |-> cooler_stall_oe_o; endproperty
    a_stall: assert property (p_stall) else $error("stall not driven");
    property p_refoff; ref_select_o |-> !cooler_stall_oe_o; endproperty
    a_refoff: assert property (p_refoff) else $error("stall driven as reference");
    c_latched: cover property (!comp && $rose(alert_oe_o));
    c_comp: cover property (comp && $rose(alert_oe_o));
    c_ref: cover property ($rose(ref_select_o));
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    reg        clk_sys_i = 1'b0;
    reg        rst_i     = 1'b1;
    reg        ce        = 1'b1;
    reg        wr, rd, lsmp, rsmp, ara_req, dfault, lcrit, rcrit, ontime, pdrive, pin, stall, alarm;
    reg  [7:0] addr, wdata, ltemp, rtemp;
    reg  [3:0] dly;
    wire [7:0] rdata;
    wire       alert_oe, st_oe, refsel, ara_done, line;
    integer    n_mismatch = 0, checked = 0, cycles = 0, i;
    localparam [55:0] TAB = 56'h08090A4F505120;
    alert_status_mask_logic u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .ara_done_i(ara_done), .local_sample_i(lsmp),
        .remote_sample_i(rsmp), .local_temp_i(ltemp), .remote_temp_i(rtemp), .local_high_lim_i(8'h50),
        .local_low_lim_i(8'h10), .remote_high_lim_i(8'h50), .remote_low_lim_i(8'h10), .diode_fault_i(dfault),
        .local_crit_i(lcrit), .remote_crit_i(rcrit), .ontime_exceed_i(ontime), .overtemp_pin_drive_i(pdrive),
        .overtemp_pin_i(pin), .fan_stall_i(stall), .fan_alarm_i(alarm), .reg_rdata_o(rdata), .alert_o(),
        .alert_oe_o(alert_oe), .cooler_stall_output_o(), .cooler_stall_oe_o(st_oe), .ref_select_o(refsel));
    alert_host_model u_host (.clk_sys_i(clk_sys_i), .alert_oe_i(alert_oe), .ara_req_i(ara_req),
        .delay_i(dly), .alert_line_o(line), .ara_done_o(ara_done));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task wrr(input [7:0] a, input [7:0] d);
        begin
            addr = a;
            wdata = d;
            wr = 1'b1;
            cyc(1);
            wr = 1'b0;
            cyc(1);
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            addr = a;
            rd = 1'b1;
            cyc(1);
            rd = 1'b0;
            chk(rdata, exp);
            cyc(1);
        end
    endtask
    task smp(input integer l, input integer r);
        begin
            lsmp = l[0];
            rsmp = r[0];
            cyc(1);
            {lsmp, rsmp} = 2'b00;
            cyc(1);
        end
    endtask
    // settle, then compare the resolved alert line
    task al(input integer e);
        begin
            cyc(3);
            chk({7'h00, line}, {7'h00, e[0]});
        end
    endtask
    task ara(input [3:0] d);
        integer k;
        begin
            dly = d;
            ara_req = 1'b1;
            k = 0;
            @(posedge clk_sys_i);
            while (ara_done !== 1'b1 && k < 20) begin
                @(posedge clk_sys_i);
                k = k + 1;
            end
            cyc(1);
            ara_req = 1'b0;
            chk({7'h00, (k < 20)}, 8'h01);
        end
    endtask
    task final_report;
        begin
            $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    initial begin
        {wr, rd, lsmp, rsmp, ara_req, dfault, lcrit, rcrit, ontime, pdrive, pin, stall, alarm} = 13'h0000;
        {addr, wdata, ltemp, rtemp, dly} = {16'h0000, 16'h3030, 4'h0};
        cyc(16);
        rst_i = 1'b0;
        for (i = 0; i < 7; i = i + 1)
            rdc(TAB[55-8*i -: 8], 8'h00);
        wrr(8'h08, 8'hFF);
        rdc(8'h08, 8'hF8);
        wrr(8'h09, 8'hFF);
        rdc(8'h09, 8'h1C);
        wrr(8'h0A, 8'hFF);
        rdc(8'h0A, 8'hC0);
        wrr(8'h08, 8'h00);
        wrr(8'h0A, 8'h00);
        ce = 1'b0;
        wrr(8'h08, 8'hFF);
        ce = 1'b1;
        rdc(8'h08, 8'h00);
        $display("test registers done");
        ltemp = 8'h50;
        smp(1, 0);
        al(0);
        ltemp = 8'h30;
        smp(1, 0);
        al(0);
        rdc(8'h4F, 8'h80);
        al(1);
        ltemp = 8'h10;
        smp(1, 0);
        rdc(8'h4F, 8'h00);
        $display("test latched done");
        {stall, alarm, ltemp} = {2'b11, 8'h0F};
        smp(1, 0);
        al(0);
        ltemp = 8'h30;
        smp(1, 0);
        rdc(8'h4F, 8'h40);
        al(0);
        {stall, alarm} = 2'b00;
        rdc(8'h51, 8'hC1);
        al(1);
        wrr(8'h09, 8'h1C);
        dfault = 1'b1;
        pin = 1'b1;
        al(1);
        dfault = 1'b0;
        rdc(8'h4F, 8'h08);
        wrr(8'h09, 8'h00);
        al(0);
        rdc(8'h50, 8'h04);
        pin = 1'b0;
        rdc(8'h50, 8'h04);
        al(1);
        $display("test masks done");
        wrr(8'h01, 8'h08);
        pin = 1'b1;
        al(1);
        {lcrit, rcrit, ontime, pdrive} = 4'hF;
        al(0);
        {lcrit, rcrit, ontime, pdrive, pin} = 5'h00;
        al(1);
        rdc(8'h50, 8'hDC);
        wrr(8'h01, 8'h00);
        $display("test comparator done");
        stall = 1'b1;
        cyc(3);
        chk({6'h00, st_oe, refsel}, 8'h02);
        wrr(8'h04, 8'h80);
        cyc(3);
        chk({6'h00, st_oe, refsel}, 8'h01);
        wrr(8'h04, 8'h00);
        stall = 1'b0;
        rdc(8'h51, 8'h81);
        al(1);
        $display("test cooler pin done");
        for (i = 0; i < 4; i = i + 1) begin
            wrr(8'h06, 8'h01 << i);
            ltemp = 8'h50;
            repeat (i) smp(1, 0);
            al(1);
            smp(1, 0);
            al(0);
            ltemp = 8'h30;
            rdc(8'h4F, 8'h80);
            al(1);
        end
        {ltemp, rtemp} = 16'h5050;
        repeat (3) smp(1, 0);
        smp(0, 1);
        al(1);
        smp(1, 0);
        al(0);
        ara(4'h5);
        al(1);
        repeat (4) smp(1, 0);
        al(0);
        {ltemp, rtemp} = 16'h3030;
        ara(4'h0);
        al(1);
        rdc(8'h4F, 8'h00);
        $display("test fault queue done");
        final_report;
    end
endmodule
bind alert_status_mask_logic alert_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .ara_done_i(ara_done_i), .fan_stall_i(fan_stall_i), .reg_rdata_o(reg_rdata_o), .alert_o(alert_o),
    .alert_oe_o(alert_oe_o), .cooler_stall_output_o(cooler_stall_output_o),
    .cooler_stall_oe_o(cooler_stall_oe_o), .ref_select_o(ref_select_o));
